// File: rtl/sbl_loader.sv
// Serial boot loader: rate detect, handshake, program download to RAM.
// Assumes rx pin synchronous, RAM write port takes one byte per cycle,
// flash erase engine answers erase_req with done and pass/fail.
`timescale 1ns/1ps
module sbl_loader #(
  parameter int unsigned DIV_W = sbl_pkg::DIV_W
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             boot_mode,
  input  wire logic             loader_receive_pin,
  output logic                  loader_transmit_pin,
  output logic                  ram_we_reg,
  output logic [19:0]           ram_addr_reg,
  output logic [7:0]            ram_wdata_reg,
  input  wire logic             flash_written,
  output logic                  erase_req_reg,
  input  wire logic             erase_done,
  input  wire logic             erase_fail,
  output logic                  jump_reg,
  output logic [19:0]           jump_addr_reg,
  output logic                  loader_region_free_reg,
  output logic                  halted_reg,
  output logic [DIV_W-1:0]      baud_divisor_register,
  output logic                  receive_enable_bit,
  output logic                  transmit_enable_bit
);

  // Elaboration check: divisor must fit the low period counter
  if (DIV_W < 8 || DIV_W > sbl_pkg::CNT_W) begin : g_bad_div_w
    $error("sbl_loader: bad DIV_W");
  end

  sbl_pkg::sbl_state_t         state_reg;
  logic [sbl_pkg::CNT_W-1:0]   low_cnt_reg;
  logic [sbl_pkg::CNT_W+1:0]   low_sum_reg;
  logic [2:0]                  meas_cnt_reg;
  logic [7:0]                  ready_cnt_reg;
  logic                        rx_prev_reg;
  logic [15:0]                 count_reg;
  logic [15:0]                 recv_reg;
  logic                        tx_start_reg;
  logic [7:0]                  tx_byte_reg;
  logic                        tx_busy;
  logic                        tx_line;
  logic                        rx_valid;
  logic [7:0]                  rx_data;
  logic [sbl_pkg::CNT_W+1:0]   div_calc;

  // average bit period over four low runs of nine bit times each
  assign div_calc = (sbl_pkg::CNT_W+2)'(low_sum_reg
                    / (sbl_pkg::BITS_PER_ZERO * sbl_pkg::LOW_MEASURES));

  // ----------------------------------------------------------------
  // Serial channel
  // ----------------------------------------------------------------
  // one asynchronous channel carries all loader traffic
  sbl_uart #(.DIV_W(DIV_W)) u_uart (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .divisor      (baud_divisor_register),
    .rx_enable    (receive_enable_bit),
    .tx_enable    (transmit_enable_bit),
    .rx           (loader_receive_pin),
    .tx_reg       (tx_line),
    .tx_start     (tx_start_reg),
    .tx_data      (tx_byte_reg),
    .tx_busy_reg  (tx_busy),
    .rx_valid_reg (rx_valid),
    .rx_data_reg  (rx_data)
  );

  // Pin register keeps output straight from a flop; high when idle
  always_ff @(posedge sys_clk) begin
    if (reset) loader_transmit_pin <= 1'b1;
    else       loader_transmit_pin <= tx_line;
  end

  // ----------------------------------------------------------------
  // Low period measurement
  // ----------------------------------------------------------------
  // count each low run of the receive pin and accumulate
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_prev_reg  <= 1'b1;
      low_cnt_reg  <= '0;
      low_sum_reg  <= '0;
      meas_cnt_reg <= 3'h0;
    end else begin
      rx_prev_reg <= loader_receive_pin;
      if (state_reg != sbl_pkg::SBL_MEASURE) begin
        low_cnt_reg  <= '0;
        low_sum_reg  <= '0;
        meas_cnt_reg <= 3'h0;
      end else if (!loader_receive_pin) begin
        // Only runs whose falling edge is seen here count; a partial run is skipped
        if ((low_cnt_reg != '0 || rx_prev_reg) && low_cnt_reg != '1)
          low_cnt_reg <= low_cnt_reg + 1'b1;
      end else if (!rx_prev_reg && low_cnt_reg != '0) begin
        // Rising edge closes one 0x00 low run
        low_sum_reg  <= low_sum_reg + (sbl_pkg::CNT_W+2)'(low_cnt_reg);
        meas_cnt_reg <= meas_cnt_reg + 3'h1;
        low_cnt_reg  <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Loader sequence
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg              <= sbl_pkg::SBL_WAIT_READY;
      ready_cnt_reg          <= 8'h00;
      count_reg              <= 16'h0000;
      recv_reg               <= 16'h0000;
      tx_start_reg           <= 1'b0;
      tx_byte_reg            <= 8'h00;
      ram_we_reg             <= 1'b0;
      ram_addr_reg           <= sbl_pkg::USER_RAM_BASE;
      ram_wdata_reg          <= 8'h00;
      erase_req_reg          <= 1'b0;
      jump_reg               <= 1'b0;
      jump_addr_reg          <= sbl_pkg::BOOT_RAM_BASE;
      loader_region_free_reg <= 1'b0;
      halted_reg             <= 1'b0;
      baud_divisor_register  <= '1;
      receive_enable_bit     <= 1'b0;
      transmit_enable_bit    <= 1'b0;
    end else begin
      tx_start_reg <= 1'b0;
      ram_we_reg   <= 1'b0;
      jump_reg     <= 1'b0;
      case (state_reg)
        // hold off measuring for the ready interval
        sbl_pkg::SBL_WAIT_READY: begin
          if (boot_mode) begin
            if (ready_cnt_reg == 8'(sbl_pkg::READY_STATES - 1))
              state_reg <= sbl_pkg::SBL_MEASURE;
            else
              ready_cnt_reg <= ready_cnt_reg + 8'h01;
          end
        end
        // load divisor once enough low runs are seen
        sbl_pkg::SBL_MEASURE: begin
          // divisor follows the measured host rate while the bit period fits in DIV_W bits; a zero result loads 1
          if (meas_cnt_reg == 3'(sbl_pkg::LOW_MEASURES)) begin
            baud_divisor_register <= (div_calc == '0) ? DIV_W'(1) : DIV_W'(div_calc);
            transmit_enable_bit   <= 1'b1;
            state_reg             <= sbl_pkg::SBL_SEND_DONE;
          end
        end
        sbl_pkg::SBL_SEND_DONE: begin
          tx_byte_reg        <= sbl_pkg::BYTE_ADJ_DONE;
          tx_start_reg       <= 1'b1;
          receive_enable_bit <= 1'b1;
          state_reg          <= sbl_pkg::SBL_WAIT_SYNC;
        end
        // stray 0x00 from the host is ignored until 0x55
        sbl_pkg::SBL_WAIT_SYNC: begin
          if (rx_valid && rx_data == sbl_pkg::BYTE_SYNC) state_reg <= sbl_pkg::SBL_SEND_ACK;
        end
        sbl_pkg::SBL_SEND_ACK: begin
          if (!tx_busy && !tx_start_reg) begin
            tx_byte_reg  <= sbl_pkg::BYTE_SYNC_ACK;
            tx_start_reg <= 1'b1;
            state_reg    <= sbl_pkg::SBL_COUNT_HI;
          end
        end
        // echo each count byte as it arrives
        sbl_pkg::SBL_COUNT_HI, sbl_pkg::SBL_COUNT_LO: begin
          if (rx_valid) begin
            tx_byte_reg  <= rx_data;
            tx_start_reg <= 1'b1;
            count_reg    <= {count_reg[7:0], rx_data};
            recv_reg     <= 16'h0000;
            if (state_reg == sbl_pkg::SBL_COUNT_HI) begin
              state_reg <= sbl_pkg::SBL_COUNT_LO;
            end else if ({count_reg[7:0], rx_data} == 16'h0000) begin
              state_reg <= sbl_pkg::SBL_ERASE;
            end else begin
              state_reg <= sbl_pkg::SBL_PROGRAM;
            end
          end
        end
        // echo each program byte; store in order those inside the user area
        sbl_pkg::SBL_PROGRAM: begin
          if (rx_valid) begin
            tx_byte_reg  <= rx_data;
            tx_start_reg <= 1'b1;
            recv_reg     <= recv_reg + 16'h0001;
            // writes never pass the end of the user area
            if (recv_reg < sbl_pkg::USER_RAM_BYTES) begin
              ram_we_reg    <= 1'b1;
              ram_addr_reg  <= sbl_pkg::USER_RAM_BASE + 20'(recv_reg);
              ram_wdata_reg <= rx_data;
            end
            if (recv_reg + 16'h0001 == count_reg) state_reg <= sbl_pkg::SBL_ERASE;
          end
        end
        // check flash state; erase all when written
        sbl_pkg::SBL_ERASE: begin
          if (!flash_written && !erase_req_reg) begin
            state_reg <= sbl_pkg::SBL_RUN;
          end else begin
            erase_req_reg <= 1'b1;
            if (erase_req_reg && erase_done) begin
              erase_req_reg <= 1'b0;
              state_reg     <= erase_fail ? sbl_pkg::SBL_SEND_ERR : sbl_pkg::SBL_RUN;
            end
          end
        end
        // one 0xFF after the last echo, then halt
        sbl_pkg::SBL_SEND_ERR: begin
          if (!tx_busy && !tx_start_reg) begin
            tx_byte_reg  <= sbl_pkg::BYTE_ERASE_ERR;
            tx_start_reg <= 1'b1;
            state_reg    <= sbl_pkg::SBL_HALT;
          end
        end
        sbl_pkg::SBL_HALT: begin
          halted_reg <= 1'b1;
        end
        // wait out the last echo, drop enables, keep divisor
        sbl_pkg::SBL_RUN: begin
          if (!tx_busy && !tx_start_reg && !jump_reg && !loader_region_free_reg) begin
            receive_enable_bit     <= 1'b0;
            transmit_enable_bit    <= 1'b0;
            // branch to the user program; loader area released
            jump_reg               <= 1'b1;
            jump_addr_reg          <= sbl_pkg::USER_RAM_BASE;
            loader_region_free_reg <= 1'b1;
          end
        end
        default: state_reg <= sbl_pkg::SBL_WAIT_READY;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_jump_addr;
    @(posedge sys_clk) disable iff (reset)
      jump_reg |-> jump_addr_reg == sbl_pkg::USER_RAM_BASE && !transmit_enable_bit;
  endproperty
  a_jump_addr: assert property (p_jump_addr) else $error("jump wrong");

  property p_ram_range;
    @(posedge sys_clk) disable iff (reset)
      ram_we_reg |-> ram_addr_reg >= sbl_pkg::USER_RAM_BASE
                     && ram_addr_reg <= sbl_pkg::USER_RAM_LAST;
  endproperty
  a_ram_range: assert property (p_ram_range) else $error("RAM write out of range");

  property p_echo;
    @(posedge sys_clk) disable iff (reset)
      rx_valid && state_reg == sbl_pkg::SBL_PROGRAM
        |=> tx_start_reg && tx_byte_reg == $past(rx_data);
  endproperty
  a_echo: assert property (p_echo) else $error("byte not echoed");

  property p_keep_div;
    @(posedge sys_clk) disable iff (reset)
      $rose(jump_reg) |-> $stable(baud_divisor_register) && !receive_enable_bit;
  endproperty
  a_keep_div: assert property (p_keep_div) else $error("divisor lost");

  property p_adj_done;
    @(posedge sys_clk) disable iff (reset)
      state_reg == sbl_pkg::SBL_SEND_DONE
        |=> tx_start_reg && tx_byte_reg == sbl_pkg::BYTE_ADJ_DONE;
  endproperty
  a_adj_done: assert property (p_adj_done) else $error("adjust done byte wrong");

  property p_sync_ack;
    @(posedge sys_clk) disable iff (reset)
      state_reg == sbl_pkg::SBL_SEND_ACK && !tx_busy && !tx_start_reg
        |=> tx_start_reg && tx_byte_reg == sbl_pkg::BYTE_SYNC_ACK
            && state_reg == sbl_pkg::SBL_COUNT_HI;
  endproperty
  a_sync_ack: assert property (p_sync_ack) else $error("sync answer wrong");

  property p_ready_wait;
    @(posedge sys_clk) disable iff (reset)
      state_reg == sbl_pkg::SBL_MEASURE
        |-> ready_cnt_reg == 8'(sbl_pkg::READY_STATES - 1);
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("measured too early");

endmodule // sbl_loader

// File: rtl/sbl_pkg.sv
// Package for the serial boot loader: constants, codes, timing counts.
// Assumes a 200 MHz system clock; every user writes sbl_pkg::name.
package sbl_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned READY_STATES     = 100;  // States before low period measurement
  localparam int unsigned BITS_PER_ZERO    = 9;    // Start bit plus eight zero data bits
  localparam int unsigned LOW_MEASURES     = 4;    // Low periods averaged into divisor
  localparam int unsigned DIV_W            = 20;   // Divisor width, cycles per bit
  localparam int unsigned CNT_W            = 24;   // Low period counter width

  // ----------------------------------------------------------------
  // Protocol bytes
  // ----------------------------------------------------------------
  localparam logic [7:0]  BYTE_ADJ_DONE    = 8'h00;
  localparam logic [7:0]  BYTE_SYNC        = 8'h55;
  localparam logic [7:0]  BYTE_SYNC_ACK    = 8'hAA;
  localparam logic [7:0]  BYTE_ERASE_ERR   = 8'hFF;

  // ----------------------------------------------------------------
  // Memory map
  // ----------------------------------------------------------------
  localparam logic [19:0] USER_RAM_BASE    = 20'hFF300;
  localparam logic [19:0] USER_RAM_LAST    = 20'hFFEFF;
  localparam logic [19:0] BOOT_RAM_BASE    = 20'hFEF10;
  localparam logic [19:0] BOOT_RAM_LAST    = 20'hFF2FF;
  localparam logic [15:0] USER_RAM_BYTES   = 16'h0C00;  // 3.0 kbyte user area

  // Loader sequence states
  typedef enum logic [3:0] {
    SBL_WAIT_READY, SBL_MEASURE, SBL_SEND_DONE, SBL_WAIT_SYNC, SBL_SEND_ACK,
    SBL_COUNT_HI, SBL_COUNT_LO, SBL_PROGRAM, SBL_ERASE, SBL_SEND_ERR,
    SBL_HALT, SBL_RUN
  } sbl_state_t;

endpackage

// File: rtl/sbl_uart.sv
// Async serial byte transceiver, 8 data bits, 1 stop bit, no parity.
// Assumes rx is already synchronous to sys_clk and divisor is stable while enabled.
`timescale 1ns/1ps
module sbl_uart #(
  parameter int unsigned DIV_W = 20
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [DIV_W-1:0] divisor,
  input  wire logic             rx_enable,
  input  wire logic             tx_enable,
  input  wire logic             rx,
  output logic                  tx_reg,
  input  wire logic             tx_start,
  input  wire logic [7:0]       tx_data,
  output logic                  tx_busy_reg,
  output logic                  rx_valid_reg,
  output logic [7:0]            rx_data_reg
);

  // Elaboration check: counters need room for a useful bit period
  if (DIV_W < 4) begin : g_bad_div_w
    $error("sbl_uart: DIV_W too small");
  end

  logic [DIV_W-1:0] tx_cnt_reg;
  logic [3:0]       tx_bit_reg;
  logic [9:0]       tx_shift_reg;
  logic [DIV_W-1:0] rx_cnt_reg;
  logic [3:0]       rx_bit_reg;
  logic             rx_busy_reg;
  logic [7:0]       rx_shift_reg;

  // ----------------------------------------------------------------
  // Transmitter: start, eight data bits LSB first, one stop
  // ----------------------------------------------------------------
  // eight data bits, one stop, no parity
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_reg       <= 1'b1;
      tx_busy_reg  <= 1'b0;
      tx_cnt_reg   <= '0;
      tx_bit_reg   <= 4'h0;
      tx_shift_reg <= 10'h3FF;
    end else if (!tx_busy_reg) begin
      tx_reg <= 1'b1;                      // Idle line stays high
      if (tx_start && tx_enable) begin
        tx_shift_reg <= {1'b1, tx_data, 1'b0};
        tx_busy_reg  <= 1'b1;
        tx_bit_reg   <= 4'h0;
        tx_cnt_reg   <= '0;
      end
    end else begin
      tx_reg <= tx_shift_reg[0];
      if (tx_cnt_reg == divisor - 1'b1) begin
        tx_cnt_reg   <= '0;
        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
        if (tx_bit_reg == 4'h9) tx_busy_reg <= 1'b0;
        tx_bit_reg   <= tx_bit_reg + 4'h1;
      end else begin
        tx_cnt_reg <= tx_cnt_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receiver: mid-bit sampling, frame with bad stop bit dropped
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_busy_reg  <= 1'b0;
      rx_cnt_reg   <= '0;
      rx_bit_reg   <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
      rx_data_reg  <= 8'h00;
    end else begin
      rx_valid_reg <= 1'b0;
      if (!rx_enable) begin
        rx_busy_reg <= 1'b0;
      end else if (!rx_busy_reg) begin
        if (!rx) begin
          rx_busy_reg <= 1'b1;
          rx_bit_reg  <= 4'h0;
          rx_cnt_reg  <= divisor >> 1;     // Half a bit to mid start
        end
      end else if (rx_cnt_reg == '0) begin
        rx_cnt_reg <= divisor - 1'b1;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0) begin
          if (rx) rx_busy_reg <= 1'b0;     // Glitch, not a start bit
        end else if (rx_bit_reg == 4'h9) begin
          rx_busy_reg <= 1'b0;
          if (rx) begin
            rx_valid_reg <= 1'b1;
            rx_data_reg  <= rx_shift_reg;
          end
        end else begin
          rx_shift_reg <= {rx, rx_shift_reg[7:1]};
        end
      end else begin
        rx_cnt_reg <= rx_cnt_reg - 1'b1;
      end
    end
  end

endmodule // sbl_uart

// File: verification/sbl_host_model.sv
// Host side of the loader link: sends and receives 8N1 serial bytes.
// Assumes the lines idle high through pull-ups and one bit lasts BIT clocks.
`timescale 1ns/1ps
module sbl_host_model #(
  parameter int unsigned BIT = 16
) (
  input  wire logic sys_clk,
  input  wire logic from_dev,
  output logic      to_dev
);
  // ----------------------------------------------------------------
  // Line driver
  // ----------------------------------------------------------------
  // Idle level of the pulled-up line
  initial to_dev = 1'b1;

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      #1 to_dev = f[i];
      repeat (BIT - 1) @(posedge sys_clk);
    end
  endtask

  // ----------------------------------------------------------------
  // Line receiver
  // ----------------------------------------------------------------
  // sample mid-bit, LSB first, check stop
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    ok = 1'b0;
    b = 8'h00;
    n = 0;
    while (from_dev !== 1'b0 && n < 20000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n < 20000) begin
      repeat (BIT / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge sys_clk);
        #1 b[i] = from_dev;
      end
      repeat (BIT) @(posedge sys_clk);
      #1 ok = (from_dev === 1'b1);
    end
  endtask
endmodule // sbl_host_model

// File: verification/tb_top.sv
// Testbench for the serial boot loader: rate detect, handshake, download, erase.
// Assumes a 5 ns clock; the host runs a short bit period to keep the run brief.
`timescale 1ns/1ps
module tb_top;
  // host keeps one fixed bit rate
  localparam int unsigned BIT = 16;
  localparam int unsigned DW  = sbl_pkg::DIV_W;

  logic          sys_clk, reset, boot_mode, host_to_dev, dev_to_host;
  logic          ram_we_reg, flash_written, erase_req_reg, erase_done, erase_fail;
  logic          jump_reg, loader_region_free_reg, halted_reg;
  logic          receive_enable_bit, transmit_enable_bit;
  logic [19:0]   ram_addr_reg, jump_addr_reg;
  logic [7:0]    ram_wdata_reg;
  logic [DW-1:0] baud_divisor_register;
  logic [19:0]   wa[$];
  logic [7:0]    wd[$];
  logic          erase_seen, fail_mode;
  int            miscompares, checks_done;

  // ----------------------------------------------------------------
  // Clock, instances
  // ----------------------------------------------------------------
  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;

  sbl_loader DUT (.sys_clk(sys_clk), .reset(reset), .boot_mode(boot_mode),
    .loader_receive_pin(host_to_dev), .loader_transmit_pin(dev_to_host),
    .ram_we_reg(ram_we_reg), .ram_addr_reg(ram_addr_reg), .ram_wdata_reg(ram_wdata_reg),
    .flash_written(flash_written), .erase_req_reg(erase_req_reg),
    .erase_done(erase_done), .erase_fail(erase_fail), .jump_reg(jump_reg),
    .jump_addr_reg(jump_addr_reg), .loader_region_free_reg(loader_region_free_reg),
    .halted_reg(halted_reg), .baud_divisor_register(baud_divisor_register),
    .receive_enable_bit(receive_enable_bit), .transmit_enable_bit(transmit_enable_bit));

  sbl_host_model #(.BIT(BIT)) host (.sys_clk(sys_clk), .from_dev(dev_to_host),
    .to_dev(host_to_dev));

  // ----------------------------------------------------------------
  // Flash erase engine and RAM write monitor
  // ----------------------------------------------------------------
  // Answers each erase request after eight cycles
  always begin
    @(posedge sys_clk iff erase_req_reg === 1'b1);
    erase_seen = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1 erase_done = 1'b1;
    erase_fail = fail_mode;
    @(posedge sys_clk);
    #1 erase_done = 1'b0;
    erase_fail = 1'b0;
    @(posedge sys_clk);
  end

  // Logs every RAM write pulse
  always @(posedge sys_clk) begin
    if (ram_we_reg === 1'b1) begin
      wa.push_back(ram_addr_reg);
      wd.push_back(ram_wdata_reg);
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic do_reset(input logic written, input logic fail);
    @(posedge sys_clk);
    #1 reset = 1'b1;
    flash_written = written;
    fail_mode = fail;
    repeat (3) @(posedge sys_clk);
    #1 reset = 1'b0;
    erase_seen = 1'b0;
    wa.delete();
    wd.delete();
  endtask

  // Sends one byte and takes its echo
  task automatic xfer(input logic [7:0] b);
    logic [7:0] r;
    logic       ok;
    fork
      host.send_byte(b);
      host.recv_byte(r, ok);
    join
    check({23'h0, ok, r}, {24'h1, b}, "echo");
  endtask

  task automatic handshake();
    logic [7:0] r;
    logic       ok, got;
    got = 1'b0;
    // zero stream until the device answers
    fork
      while (!got) host.send_byte(8'h00);
      begin
        host.recv_byte(r, ok);
        got = 1'b1;
      end
    join
    check({23'h0, ok, r}, 32'h100, "adjust done byte");
    check(baud_divisor_register, BIT, "divisor");
    check(receive_enable_bit, 1'b1, "receive on");
    // sync byte after the adjust byte, whether or not it was good
    fork
      host.send_byte(8'h55);
      host.recv_byte(r, ok);
    join
    check({23'h0, ok, r}, 32'h1AA, "sync answer");
  endtask

  task automatic wait_jump(output logic seen);
    seen = 1'b0;
    for (int n = 0; n < 4000 && !seen; n++) begin
      @(posedge sys_clk);
      #1 seen = (jump_reg === 1'b1);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values();
    do_reset(1'b0, 1'b0);
    check(dev_to_host, 1'b1, "tx idle");
    check(baud_divisor_register, {DW{1'b1}}, "divisor reset");
    check({receive_enable_bit, transmit_enable_bit, jump_reg, halted_reg}, 0, "flags");
  endtask

  task automatic test_download_erase();
    logic       seen;
    logic [7:0] prog[3];
    prog = '{8'hA5, 8'h3C, 8'hC3};
    do_reset(1'b1, 1'b0);
    handshake();
    xfer(8'h00);
    xfer(8'h03);
    foreach (prog[i]) xfer(prog[i]);
    check(wa.size(), 3, "write count");
    for (int i = 0; i < 3 && i < wa.size(); i++) begin
      check(wa[i], sbl_pkg::USER_RAM_BASE + i, "write addr");
      check(wd[i], prog[i], "write data");
    end
    wait_jump(seen);
    check(seen, 1'b1, "jump");
    check(erase_seen, 1'b1, "erase before run");
    check(jump_addr_reg, sbl_pkg::USER_RAM_BASE, "jump addr");
    check({receive_enable_bit, transmit_enable_bit}, 2'b00, "enables off");
    check(baud_divisor_register, BIT, "divisor kept");
    check(loader_region_free_reg, 1'b1, "region free");
    check(dev_to_host, 1'b1, "tx high");
  endtask

  task automatic test_blank_flash();
    logic seen;
    do_reset(1'b0, 1'b0);
    handshake();
    xfer(8'h00);
    xfer(8'h00);
    wait_jump(seen);
    check(seen, 1'b1, "jump");
    check(erase_seen, 1'b0, "no erase");
    check(wa.size(), 0, "no writes");
  endtask

  task automatic test_erase_fail();
    logic       seen, ok;
    logic [7:0] r;
    do_reset(1'b1, 1'b1);
    handshake();
    xfer(8'h00);
    xfer(8'h00);
    host.recv_byte(r, ok);
    check({23'h0, ok, r}, 32'h1FF, "erase error byte");
    check(halted_reg, 1'b1, "halted");
    wait_jump(seen);
    check(seen, 1'b0, "no jump");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    boot_mode = 1'b1;
    flash_written = 1'b0;
    erase_done = 1'b0;
    erase_fail = 1'b0;
    fail_mode = 1'b0;
    erase_seen = 1'b0;
    miscompares = 0;
    checks_done = 0;
    test_reset_values();
    test_download_erase();
    test_blank_flash();
    test_erase_fail();
    test_done();
  end
endmodule // tb_top
